// File: tpc_pkg.sv
// Purpose: shared constants, state codes and carriers for the tuner protocol converter
// Assumes: 100 MHz mclk, control sequence stepped on a 10 ms tick
// Notes:   all times are kept in ms and turned into whole ticks here
package tpc_pkg;

    // clock and tick timebase
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 10000000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_MS       = 10;

    // sequence delays in milliseconds
    localparam int RESAMPLE_MS   = 100;   // request line resample point
    localparam int RST_PULSE_MS  = 100;   // reset drive width for bypass
    localparam int PRE_KEY_MS    = 10;    // unlock settle before keying
    localparam int POST_KEY_MS   = 150;   // key settle before watching request
    localparam int TUNE_TO_MS    = 5000;  // longest wait for a match
    localparam int XCVR_ERR_MS   = 320;   // wait before checking transceiver error
    localparam int TNR_ERR_MS    = 600;   // covers the tuner's 500 ms failure drop

    // least times round up to whole ticks
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] RESAMPLE_T = CNT_W'((RESAMPLE_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [CNT_W-1:0] RST_T      = CNT_W'((RST_PULSE_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [CNT_W-1:0] PRE_KEY_T  = CNT_W'((PRE_KEY_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [CNT_W-1:0] POST_KEY_T = CNT_W'((POST_KEY_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [CNT_W-1:0] TUNE_TO_T  = CNT_W'(TUNE_TO_MS / TICK_MS);
    localparam logic [CNT_W-1:0] XCVR_ERR_T = CNT_W'((XCVR_ERR_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [CNT_W-1:0] TNR_ERR_T  = CNT_W'((TNR_ERR_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [CNT_W-1:0] ONE_T      = CNT_W'(1);

    // tick divider width, enough for 1,000,000 cycles
    localparam int DIV_W = 20;

    // sampled inputs from the two partners
    typedef struct packed {
        logic start;   // transceiver tune request, high = asserted
        logic tuned;   // tuner match found, high = asserted
    } tpc_in_t;

    // control sequence states
    typedef enum logic [4:0] {
        ST_IDLE,
        ST_POST_START,
        ST_TEST_START,
        ST_BYP_NEG_LOCK,
        ST_BYP_RESET,
        ST_BYP_NEG_RESET,
        ST_BYP_LOCK,
        ST_TUNE_UNLOCK,
        ST_PRE_KEY,
        ST_ASSERT_KEY,
        ST_POST_KEY,
        ST_WAIT_START_NEG,
        ST_WAIT_TUNED,
        ST_NEG_KEY,
        ST_TUNE_LOCK,
        ST_XCVR_ERR_DLY,
        ST_TEST_XCVR,
        ST_TNR_ERR_DLY,
        ST_TEST_TNR
    } tpc_state_t;

endpackage

// File: tpc_insync.sv
// Purpose: three-flop pin synchroniser, a change counts once the last two agree
// Assumes: inputs are asynchronous pins
// Notes:   stage one feeds stage two only
`timescale 1ns/100ps
module tpc_insync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // pins and clean levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] lvl_o
);

    // all state of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;   // metastable catch
        logic [W-1:0] s2;   // first clean stage
        logic [W-1:0] s3;   // agreement stage
        logic [W-1:0] lvl;  // accepted level
    } tpc_sync_st_t;

    tpc_sync_st_t q;
    tpc_sync_st_t d;
    logic [W-1:0] agree_lvl;   // per-bit accepted next level

    // per-bit agreement: keep old level while stages differ
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign agree_lvl[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.lvl[i];
    end

    // next state
    always_comb begin
        d     = q;
        d.s1  = pin_i;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.lvl = agree_lvl;
    end

    // state register, pins read low until settled
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lvl_o = q.lvl;

endmodule // tpc_insync

// File: tpc_converter.sv
// Purpose: converts transceiver tune/bypass requests into tuner hold line control
// Assumes: start and tuned are pins; hold line is a three-state wire resolved outside
// Notes:   sequence steps once per tick; tick period is a parameter for simulation
`timescale 1ns/100ps
module tpc_converter #(
    parameter int TICK_CYCLES = tpc_pkg::TICK_CYC   // mclk cycles per tick
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // transceiver side
    input  wire logic start_i,      // tune request pin
    output logic      key_o,        // transmit handshake
    // tuner side, three-state hold line
    input  wire logic tuned_i,      // match found pin
    input  wire logic hold_i,       // hold line readback, not needed
    output logic      hold_o,       // level driven when enabled
    output logic      hold_oe,      // high while driving
    // indicators
    output logic      led_tuned,    // match found lamp
    output logic      led_locked    // locked lamp
);

    // all state of the converter
    typedef struct packed {
        logic [tpc_pkg::DIV_W-1:0] div;   // tick divider
        logic                      tick;  // one-cycle tick pulse
        tpc_pkg::tpc_in_t          smp;   // inputs sampled at the tick
        tpc_pkg::tpc_state_t       st;    // sequence state
        logic [tpc_pkg::CNT_W-1:0] cnt;   // tick delay count
        logic                      lock;  // high drive request
        logic                      rdrv;  // low (reset) drive request
        logic                      key;   // handshake to transceiver
    } tpc_conv_st_t;

    localparam logic [tpc_pkg::DIV_W-1:0] DIV_LAST = tpc_pkg::DIV_W'(TICK_CYCLES - 1);

    tpc_conv_st_t     q;
    tpc_conv_st_t     d;
    tpc_pkg::tpc_in_t pin_lvl;   // synchronised pins
    logic             done;      // delay count expired

    // pin synchroniser for both inputs
    tpc_insync #(
        .W     (2)
    ) u_sync (
        .mclk  (mclk),
        .rst   (rst),
        .pin_i ({start_i, tuned_i}),
        .lvl_o (pin_lvl)
    );

    assign done = (q.cnt == '0);

    // next state: divider always, sequence only on the tick
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        // tick divider; pulse is registered so it lasts one cycle
        if (q.div == DIV_LAST) begin
            d.div  = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + tpc_pkg::DIV_W'(1);
        end
        if (q.tick) begin
            d.smp = pin_lvl;
            // delays count down by default, states reload as needed
            if (!done) begin
                d.cnt = q.cnt - tpc_pkg::ONE_T;
            end
            unique case (q.st)
                tpc_pkg::ST_IDLE: begin
                    if (q.smp.start) begin
                        d.st  = tpc_pkg::ST_POST_START;
                        d.cnt = tpc_pkg::RESAMPLE_T - tpc_pkg::ONE_T;
                    end
                end
                tpc_pkg::ST_POST_START: begin
                    if (done) begin
                        d.st = tpc_pkg::ST_TEST_START;
                    end
                end
                // still asserted means a full tune, released means bypass
                tpc_pkg::ST_TEST_START: begin
                    if (q.smp.start) begin
                        d.st   = tpc_pkg::ST_TUNE_UNLOCK;
                        d.lock = 1'b0;
                    end else begin
                        d.st   = tpc_pkg::ST_BYP_NEG_LOCK;
                        d.lock = 1'b0;
                        d.key  = 1'b0;
                    end
                end
                // bypass walk: unlock, reset pulse, relock
                tpc_pkg::ST_BYP_NEG_LOCK: begin
                    d.st   = tpc_pkg::ST_BYP_RESET;
                    d.rdrv = 1'b1;
                    d.cnt  = tpc_pkg::RST_T - tpc_pkg::ONE_T;
                end
                tpc_pkg::ST_BYP_RESET: begin
                    if (done) begin
                        d.st   = tpc_pkg::ST_BYP_NEG_RESET;
                        d.rdrv = 1'b0;
                    end
                end
                tpc_pkg::ST_BYP_NEG_RESET: begin
                    d.st   = tpc_pkg::ST_BYP_LOCK;
                    d.lock = 1'b1;
                end
                tpc_pkg::ST_BYP_LOCK: begin
                    d.st = tpc_pkg::ST_IDLE;
                end
                // tune walk
                tpc_pkg::ST_TUNE_UNLOCK: begin
                    d.st  = tpc_pkg::ST_PRE_KEY;
                    d.cnt = tpc_pkg::PRE_KEY_T - tpc_pkg::ONE_T;
                end
                tpc_pkg::ST_PRE_KEY: begin
                    if (done) begin
                        d.st  = tpc_pkg::ST_ASSERT_KEY;
                        d.key = 1'b1;
                    end
                end
                tpc_pkg::ST_ASSERT_KEY: begin
                    d.st  = tpc_pkg::ST_POST_KEY;
                    d.cnt = tpc_pkg::POST_KEY_T - tpc_pkg::ONE_T;
                end
                tpc_pkg::ST_POST_KEY: begin
                    if (done) begin
                        d.st  = tpc_pkg::ST_WAIT_START_NEG;
                        d.cnt = tpc_pkg::TUNE_TO_T;
                    end
                end
                // transceiver drops its request once it sees the key
                tpc_pkg::ST_WAIT_START_NEG: begin
                    if (!q.smp.start || done) begin
                        d.st  = tpc_pkg::ST_WAIT_TUNED;
                        d.cnt = tpc_pkg::TUNE_TO_T;
                    end
                end
                // timeout bounds a tuner that never finds a match
                tpc_pkg::ST_WAIT_TUNED: begin
                    if (q.smp.tuned || done) begin
                        d.st  = tpc_pkg::ST_NEG_KEY;
                        d.key = 1'b0;
                    end
                end
                tpc_pkg::ST_NEG_KEY: begin
                    d.st   = tpc_pkg::ST_TUNE_LOCK;
                    d.lock = 1'b1;
                end
                tpc_pkg::ST_TUNE_LOCK: begin
                    d.st  = tpc_pkg::ST_XCVR_ERR_DLY;
                    d.cnt = tpc_pkg::XCVR_ERR_T - tpc_pkg::ONE_T;
                end
                tpc_pkg::ST_XCVR_ERR_DLY: begin
                    if (done) begin
                        d.st = tpc_pkg::ST_TEST_XCVR;
                    end
                end
                // transceiver error is checked first
                tpc_pkg::ST_TEST_XCVR: begin
                    if (q.smp.start) begin
                        d.st   = tpc_pkg::ST_BYP_NEG_LOCK;
                        d.lock = 1'b0;
                    end else begin
                        d.st  = tpc_pkg::ST_TNR_ERR_DLY;
                        d.cnt = tpc_pkg::TNR_ERR_T - tpc_pkg::ONE_T;
                    end
                end
                tpc_pkg::ST_TNR_ERR_DLY: begin
                    if (done) begin
                        d.st = tpc_pkg::ST_TEST_TNR;
                    end
                end
                // match gone (dropped or never seen) means bypass
                tpc_pkg::ST_TEST_TNR: begin
                    if (!q.smp.tuned) begin
                        d.st   = tpc_pkg::ST_BYP_NEG_LOCK;
                        d.lock = 1'b0;
                    end else begin
                        d.st = tpc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    d.st = tpc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // state register; after reset the hold line is released
    always_ff @(posedge mclk) begin
        if (rst) begin
            q    <= '0;
            q.st <= tpc_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // pin drive: reset drive wins, so high and low never overlap
    assign hold_oe    = q.rdrv | q.lock;
    assign hold_o     = q.lock & ~q.rdrv;
    assign key_o      = q.key;
    assign led_tuned  = q.smp.tuned;
    assign led_locked = q.lock & ~q.rdrv;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence byp_reset_s;
        (q.st == tpc_pkg::ST_BYP_RESET) && hold_oe && !hold_o;
    endsequence

    sequence byp_relock_s;
        (q.st == tpc_pkg::ST_BYP_LOCK) && hold_oe && hold_o;
    endsequence

    hold_no_clash_a: assert property (q.rdrv |-> hold_oe && !hold_o)
        else $error("hold line driven high during reset drive");
    tune_unlock_a: assert property ((q.st == tpc_pkg::ST_TUNE_UNLOCK) |-> !hold_oe)
        else $error("hold line not released at tune start");
    lock_on_match_a: assert property ((q.st == tpc_pkg::ST_NEG_KEY) && q.tick
        |=> (q.st == tpc_pkg::ST_TUNE_LOCK) && hold_oe && hold_o)
        else $error("tuner not locked after match");
    tnr_fail_a: assert property ((q.st == tpc_pkg::ST_TEST_TNR) && q.tick && !q.smp.tuned
        |=> (q.st == tpc_pkg::ST_BYP_NEG_LOCK) && !hold_oe)
        else $error("missing match did not start bypass");
    // the reset pulse lasts many ticks, so each end of it is checked on its own
    bypass_walk_a: assert property ((q.st == tpc_pkg::ST_BYP_NEG_LOCK) && q.tick
        |=> byp_reset_s)
        else $error("bypass walk out of order");
    bypass_relock_a: assert property ((q.st == tpc_pkg::ST_BYP_NEG_RESET) && q.tick
        |=> byp_relock_s)
        else $error("bypass did not relock");
    bypass_nokey_a: assert property ((q.st >= tpc_pkg::ST_BYP_NEG_LOCK)
        && (q.st <= tpc_pkg::ST_BYP_LOCK) && $past(q.st) == tpc_pkg::ST_TEST_START |-> !key_o)
        else $error("key raised on bypass command");
    resample_a: assert property ((q.st == tpc_pkg::ST_POST_START) && q.tick && done
        |=> (q.st == tpc_pkg::ST_TEST_START))
        else $error("request not resampled after delay");
    key_tune_a: assert property ((q.st == tpc_pkg::ST_WAIT_TUNED) |-> key_o)
        else $error("key low while waiting for match");
    xcvr_first_a: assert property ((q.st == tpc_pkg::ST_TEST_XCVR) && q.tick && q.smp.start
        |=> (q.st == tpc_pkg::ST_BYP_NEG_LOCK))
        else $error("transceiver error not acted on");
    tick_pulse_a: assert property (q.tick |=> !q.tick)
        else $error("tick wider than one cycle");
    steady_a: assert property (!q.tick |=> $stable(q.st))
        else $error("state moved between ticks");

endmodule // tpc_converter

// File: tpc_partner.sv
// Purpose: behavioural tuner on the far side of the hold line
// Assumes: tuning starts when the handshake rises with the hold line released
// Notes:   mode 0 matches, mode 1 never matches, mode 2 matches then drops
`timescale 1ns/100ps
module tpc_partner #(
    parameter int FAIL_CYC = 1000   // 500 ms as 50 ticks of 20 mclk cycles, the bench tick
) (
    // clock
    input  wire logic        mclk,
    // converter outputs
    input  wire logic        hold_o,
    input  wire logic        hold_oe,
    input  wire logic        key,
    // behaviour from the bench
    input  wire logic [1:0]  mode,
    input  wire logic [31:0] match_cyc,
    // match status, always driven
    output logic             tuned
);
    logic key_q = 1'b0;   // handshake last cycle
    int   cnt   = -1;     // cycles into a tune, -1 idle

    // changes on the falling edge, like the bench's start and reset drivers
    always @(negedge mclk) begin
        key_q <= key;
        if (hold_oe && !hold_o) begin   // reset drive clears the tuner
            tuned <= 1'b0;
            cnt   <= -1;
        end else if (key && !key_q && !hold_oe) begin   // unlocked and keyed
            tuned <= 1'b0;
            cnt   <= 0;
        end else if (cnt >= 0) begin
            cnt <= cnt + 1;
            if (mode != 2'h1 && cnt == int'(match_cyc)) begin
                tuned <= 1'b1;
                if (mode == 2'h0) cnt <= -1;   // success ends the run
            end
            if (mode == 2'h2 && cnt == int'(match_cyc) + FAIL_CYC) begin
                tuned <= 1'b0;
                cnt   <= -1;
            end
        end
    end
    initial tuned = 1'b0;
endmodule // tpc_partner

// File: tuner_protocol_converter_test.sv
// Purpose: self-checking bench for the converter with a queue model
// Assumes: short tick; sequences compared change by change
// Notes:   durations of data-dependent steps are not compared
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module tuner_protocol_converter_test;
    localparam int T = 20;   // mclk cycles per tick
    localparam logic [2:0] REL = 3'h0, LOW = 3'h4, LCK = 3'h6, KEY = 3'h1;   // {oe, o, key}
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic        start = 1'b0;
    logic        key, hold_o, hold_oe, led_tuned, led_locked, tuned;
    logic [1:0]  mode = 2'h0;
    logic [31:0] match_cyc = 32'h0;
    logic [2:0]  last = 3'h0;   // last output code seen
    logic [2:0]  act_c[$], exp_c[$];
    int          act_t[$], exp_d[$];
    int          cyc = 0, errors = 0, n_compared = 0, seed = 93321, i;
    wire         hold_w;
    assign hold_w = hold_oe ? hold_o : 1'bz;   // three-state hold line

    always #5 mclk = ~mclk;

    tpc_converter #(.TICK_CYCLES(T)) u_tpc_converter (.mclk(mclk), .rst(rst), .start_i(start), .key_o(key),
        .tuned_i(tuned), .hold_i(hold_w), .hold_o(hold_o), .hold_oe(hold_oe), .led_tuned(led_tuned),
        .led_locked(led_locked));
    tpc_partner #(.FAIL_CYC((500 / tpc_pkg::TICK_MS) * T)) u_tpc_partner (.mclk(mclk), .hold_o(hold_o),
        .hold_oe(hold_oe), .key(key), .mode(mode), .match_cyc(match_cyc), .tuned(tuned));

    // record every change of hold line and handshake, away from the launching edge
    always @(negedge mclk) begin
        cyc <= cyc + 1;
        if (!rst && {hold_oe, hold_o, key} !== last) begin
            act_c.push_back({hold_oe, hold_o, key});
            act_t.push_back(cyc);
            last <= {hold_oe, hold_o, key};
        end
    end

    // model: expected codes and ticks each code stands, -1 for free
    task automatic push(input logic [2:0] c, input int d);
        exp_c.push_back(c);
        exp_d.push_back(d);
    endtask
    task automatic predict(input bit byp, input bit from_lock, input bit fail);
        exp_c.delete();
        exp_d.delete();
        if (!byp) begin   // unlock, key, drop key, lock
            push(REL, int'(tpc_pkg::PRE_KEY_T) + 1);
            push(KEY, -1);
            push(REL, 1);
            push(LCK, -1);
        end
        if (byp || fail) begin   // unlock, reset pulse, unlock, lock
            if (!byp || from_lock) push(REL, 1);
            push(LOW, int'(tpc_pkg::RST_T));
            push(REL, 1);
            push(LCK, -1);
        end
    endtask

    // compare the recorded sequence with the model, then the lamps
    task automatic check_seq(input logic exp_tuned);
        for (i = 0; i < 40000 && act_c.size() < exp_c.size(); i++) @(posedge mclk);
        // let both error checks run out so the next request is not refused
        repeat ((int'(tpc_pkg::XCVR_ERR_T) + int'(tpc_pkg::TNR_ERR_T) + 8) * T) @(posedge mclk);
        `CHK("changes", exp_c.size(), act_c.size())
        for (i = 0; i < exp_c.size() && i < act_c.size(); i++) begin
            `CHK("hold_key", exp_c[i], act_c[i])
            if (i + 1 < act_c.size() && exp_d[i] >= 0) `CHK("cycles", exp_d[i] * T, act_t[i+1] - act_t[i])
        end
        `CHK("led_locked", 1'b1, led_locked)
        `CHK("led_tuned", exp_tuned, led_tuned)
        act_c.delete();
        act_t.delete();
    endtask

    // short request: bypass, never keyed
    task automatic bypass(input bit from_lock);
        @(negedge mclk) start = 1'b1;
        repeat ((1 + {$random(seed)} % 5) * T) @(negedge mclk);
        start = 1'b0;
        predict(1, from_lock, 0);
        check_seq(1'b0);
    endtask

    // long request: tune, tuner behaviour m, optional transceiver error
    task automatic tune(input logic [1:0] m, input bit xerr);
        mode = m;
        match_cyc = 32'((5 + {$random(seed)} % 30) * T);
        @(negedge mclk) start = 1'b1;
        for (i = 0; i < 100 * T && key !== 1'b1; i++) @(negedge mclk);
        repeat ((1 + {$random(seed)} % 4) * T) @(negedge mclk);
        start = 1'b0;
        if (xerr) begin   // raise the request again over the error check
            for (i = 0; i < 1000 * T && key !== 1'b0; i++) @(negedge mclk);
            repeat (20 * T) @(negedge mclk);
            start = 1'b1;
            repeat (25 * T) @(negedge mclk);
            start = 1'b0;
        end
        predict(0, 1, m != 2'h0 || xerr);
        check_seq(m == 2'h0 && !xerr);
    endtask

    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        bypass(0);
        tune(2'h0, 0);
        tune(2'h2, 0);
        tune(2'h1, 0);
        tune(2'h0, 1);
        tune(2'h0, 0);
        bypass(1);
        tune(2'h0, 0);
        stop_test();
    end

    // watchdog against a hung sequence
    initial begin
        repeat (100000) @(posedge mclk);
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test();
    end
endmodule // tuner_protocol_converter_test
